// *** core/tbtc_timer_pair.v ***
// Purpose: one even/odd pair of type B timers with control, count, period
// Assumes: single 50 MHz clock, APB slave, pins asynchronous to clock
//          deviceIdle comes from logic on this clock and is not synchronised
//          pready is tied high, so every access phase lasts one cycle
// Notes:   pair joins into one 32-bit timer owned by the even timer
//          a status read clears only the bits that the read returned
`timescale 1ns/1ps
`include "tbtc_regs.vh"
module tbtc_timer_pair (
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        deviceIdle,
  input  wire        extClockEven,
  input  wire        extClockOdd,
  input  wire        gateEven,
  input  wire        gateOdd,
  output wire        irq
);

  // ****************************************
  // bus decode
  // ****************************************
  wire        access = psel & penable;
  wire        wrEn   = access & pwrite;
  wire        rdEn   = access & ~pwrite;
  reg  [31:0] control  [0:1];
  reg  [15:0] count    [0:1];
  reg  [15:0] period   [0:1];
  reg  [1:0]  irqStatus;
  reg  [1:0]  irqMask;
  reg  [1:0]  wrap;

  function known;
    input [11:0] a;
    begin
      if (a == `TBTC_OFF_CONTROL0 || a == `TBTC_OFF_COUNT0 || a == `TBTC_OFF_PERIOD0) begin
        known = 1'b1;
      end else if (a == `TBTC_OFF_CONTROL1 || a == `TBTC_OFF_COUNT1) begin
        known = 1'b1;
      end else if (a == `TBTC_OFF_PERIOD1 || a == `TBTC_OFF_IRQ_STATUS) begin
        known = 1'b1;
      end else begin
        known = (a == `TBTC_OFF_IRQ_MASK);
      end
    end
  endfunction

  // single-cycle access phase; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~known(paddr);

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [2:0] syncClk [0:1];
  reg [2:0] syncGate[0:1];
  reg [1:0] clkLevel;
  reg [1:0] gateLevel;
  reg [1:0] clkLevelDly;
  wire [1:0] extPin  = {extClockOdd, extClockEven};
  wire [1:0] gatePin = {gateOdd, gateEven};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pins
      // a level counts once the second and third stages agree
      // one extra stage rejects a one-cycle glitch; an edge shows four clocks late
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          syncClk[g]     <= 3'h0;
          syncGate[g]    <= 3'h0;
          clkLevel[g]    <= 1'b0;
          gateLevel[g]   <= 1'b0;
          clkLevelDly[g] <= 1'b0;
        end else begin
          syncClk[g]     <= {syncClk[g][1:0], extPin[g]};
          syncGate[g]    <= {syncGate[g][1:0], gatePin[g]};
          if (syncClk[g][2] == syncClk[g][1]) begin
            clkLevel[g] <= syncClk[g][2];
          end
          if (syncGate[g][2] == syncGate[g][1]) begin
            gateLevel[g] <= syncGate[g][2];
          end
          clkLevelDly[g] <= clkLevel[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // control decode
  // ****************************************
  wire pairMode = control[0][`TBTC_BIT_PAIR];
  // in pair mode the even timer's settings drive both halves
  wire [31:0] effCtl0 = control[0];
  wire [31:0] effCtl1 = pairMode ? control[0] : control[1];
  wire [1:0]  idleStop;
  // pair halts on the odd timer's idle-stop bit too, so both must be clear
  assign idleStop[0] = control[0][`TBTC_BIT_IDLE_STOP]
                     | (pairMode & control[1][`TBTC_BIT_IDLE_STOP]);
  // unpaired, each half follows its own bit
  assign idleStop[1] = control[1][`TBTC_BIT_IDLE_STOP];

  function [7:0] divMinusOne;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    divMinusOne = 8'h00;
        3'h1:    divMinusOne = 8'h01;
        3'h2:    divMinusOne = 8'h03;
        3'h3:    divMinusOne = 8'h07;
        3'h4:    divMinusOne = 8'h0F;
        3'h5:    divMinusOne = 8'h1F;
        3'h6:    divMinusOne = 8'h3F;
        default: divMinusOne = 8'hFF;
      endcase
    end
  endfunction

  // ****************************************
  // prescalers and tick generation
  // ****************************************
  reg  [7:0] prescale [0:1];
  wire [1:0] tick;
  wire [1:0] running;

  generate
    for (g = 0; g < 2; g = g + 1) begin : ps
      wire [31:0] c      = (g == 0) ? effCtl0 : effCtl1;
      wire        srcExt = c[`TBTC_BIT_CLK_SRC];
      // external edge or internal bus clock
      wire        srcTick = srcExt ? (clkLevel[g] & ~clkLevelDly[g]) : 1'b1;
      // gated accumulation only counts while the gate pin is high
      wire        gateOk = (srcExt | ~c[`TBTC_BIT_GATE]) | gateLevel[g];
      assign running[g] = c[`TBTC_BIT_ENABLE]
                        & ~(deviceIdle & idleStop[g]) & gateOk;
      wire [2:0] psSel  = c[`TBTC_BIT_PS_HI:`TBTC_BIT_PS_LO];
      wire       psDone = (prescale[g] == divMinusOne(psSel));
      assign tick[g] = running[g] & srcTick & psDone;
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          prescale[g] <= 8'h00;
        end else if (~c[`TBTC_BIT_ENABLE]) begin
          prescale[g] <= 8'h00;
        end else if (running[g] & srcTick) begin
          if (psDone) begin
            prescale[g] <= 8'h00;
          end else begin
            prescale[g] <= prescale[g] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // counters
  // ****************************************
  // pair mode: one 32-bit count, odd half is the upper word
  // limitation: a count or period write lands in one half; load both while stopped
  wire [31:0] wideCount  = {count[1], count[0]};
  wire [31:0] widePeriod = {period[1], period[0]};
  wire        wideHit    = (wideCount == widePeriod);

  always @* begin
    wrap = 2'h0;
    if (pairMode) begin
      wrap[0] = tick[0] & wideHit;
    end else begin
      wrap[0] = tick[0] & (count[0] == period[0]);
      wrap[1] = tick[1] & (count[1] == period[1]);
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count[0]  <= 16'h0000;
      count[1]  <= 16'h0000;
      period[0] <= `TBTC_PERIOD_RESET;
      period[1] <= `TBTC_PERIOD_RESET;
      control[0] <= `TBTC_CONTROL_RESET;
      control[1] <= `TBTC_CONTROL_RESET;
      irqMask   <= 2'h0;
    end else begin
      if (pairMode) begin
        if (wrap[0]) begin
          count[0] <= 16'h0000;
          count[1] <= 16'h0000;
        end else if (tick[0]) begin
          {count[1], count[0]} <= wideCount + 32'h00000001;
        end
      end else begin
        if (wrap[0]) begin
          count[0] <= 16'h0000;
        end else if (tick[0]) begin
          count[0] <= count[0] + 16'h0001;
        end
        if (wrap[1]) begin
          count[1] <= 16'h0000;
        end else if (tick[1]) begin
          count[1] <= count[1] + 16'h0001;
        end
      end
      if (wrEn) begin
        // odd control bits are kept while paired; all but the idle-stop bit act only once the pair splits
        if (paddr == `TBTC_OFF_CONTROL0) begin
          control[0] <= pwdata & `TBTC_CONTROL_EVEN_MASK;
        end else if (paddr == `TBTC_OFF_CONTROL1) begin
          control[1] <= pwdata & `TBTC_CONTROL_ODD_MASK;
        end else if (paddr == `TBTC_OFF_COUNT0) begin
          count[0] <= pwdata[15:0];
        end else if (paddr == `TBTC_OFF_COUNT1) begin
          count[1] <= pwdata[15:0];
        end else if (paddr == `TBTC_OFF_PERIOD0) begin
          period[0] <= pwdata[15:0];
        end else if (paddr == `TBTC_OFF_PERIOD1) begin
          period[1] <= pwdata[15:0];
        end else if (paddr == `TBTC_OFF_IRQ_MASK) begin
          irqMask <= pwdata[1:0];
        end
      end
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  // read clears; a wrap in the same cycle still sets the bit
  wire       statusRead = rdEn & (paddr == `TBTC_OFF_IRQ_STATUS);
  // only bits the read returned are cleared, so a wrap at the setup edge stays pending
  wire [1:0] seenStatus = statusRead ? prdata[1:0] : 2'h0;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      irqStatus <= 2'h0;
    end else begin
      irqStatus <= (irqStatus & ~seenStatus) | wrap;
    end
  end
  assign irq = |(irqStatus & irqMask);

  // ****************************************
  // read data
  // ****************************************
  // gate reads zero while the external clock is selected
  function [31:0] ctlView;
    input [31:0] v;
    begin
      ctlView = v;
      if (v[`TBTC_BIT_CLK_SRC]) begin
        ctlView[`TBTC_BIT_GATE] = 1'b0;
      end
    end
  endfunction

  // latched in the setup cycle so the word stands through the access phase
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      if (paddr == `TBTC_OFF_CONTROL0) begin
        prdata <= ctlView(control[0]);
      end else if (paddr == `TBTC_OFF_CONTROL1) begin
        prdata <= ctlView(control[1]);
      end else if (paddr == `TBTC_OFF_COUNT0) begin
        prdata <= {16'h0000, count[0]};
      end else if (paddr == `TBTC_OFF_COUNT1) begin
        prdata <= {16'h0000, count[1]};
      end else if (paddr == `TBTC_OFF_PERIOD0) begin
        prdata <= {16'h0000, period[0]};
      end else if (paddr == `TBTC_OFF_PERIOD1) begin
        prdata <= {16'h0000, period[1]};
      end else if (paddr == `TBTC_OFF_IRQ_STATUS) begin
        prdata <= {30'h00000000, irqStatus};
      end else if (paddr == `TBTC_OFF_IRQ_MASK) begin
        prdata <= {30'h00000000, irqMask};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

// *** core/tbtc_regs.vh ***
// Purpose: constants for the type B timer control block
// Assumes: APB with 32-bit data, one word per register
// Notes:   offsets are byte addresses
`ifndef TBTC_REGS_VH
`define TBTC_REGS_VH
`define TBTC_OFF_CONTROL0   12'h000
`define TBTC_OFF_COUNT0     12'h004
`define TBTC_OFF_PERIOD0    12'h008
`define TBTC_OFF_CONTROL1   12'h010
`define TBTC_OFF_COUNT1     12'h014
`define TBTC_OFF_PERIOD1    12'h018
`define TBTC_OFF_IRQ_STATUS 12'h020
`define TBTC_OFF_IRQ_MASK   12'h024
`define TBTC_BIT_ENABLE     15
`define TBTC_BIT_IDLE_STOP  13
`define TBTC_BIT_GATE       7
`define TBTC_BIT_PS_HI      6
`define TBTC_BIT_PS_LO      4
`define TBTC_BIT_PAIR       3
`define TBTC_BIT_CLK_SRC    1
`define TBTC_CONTROL_EVEN_MASK 32'h0000A0FA
`define TBTC_CONTROL_ODD_MASK  32'h0000A0F2
`define TBTC_CONTROL_RESET  32'h00000000
`define TBTC_PERIOD_RESET   16'hFFFF
`define TBTC_PRESCALE_WIDTH 8
`endif

// *** test/tbtc_props.sv ***
// Purpose: port checks for the timer pair
// Assumes: one clock, reset active high
// Notes:   apb answers with no wait states
`timescale 1ns/1ps
module tbtc_props (
  input wire        clock,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        irq
);
  // ****
  // access checks
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire acc = psel && penable;
  wire rd  = acc && !pwrite;
  wire ctl = paddr == 12'h000 || paddr == 12'h010;
  wire bad = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018,
    12'h020, 12'h024});
  ctl_even_zero_a: assert property (
    rd && paddr == 12'h000 |-> (prdata & ~32'h0000A0FA) == 0) else $error("even reserved set");
  ctl_odd_zero_a: assert property (
    rd && paddr == 12'h010 |-> (prdata & ~32'h0000A0F2) == 0) else $error("odd reserved set");
  gate_reads_zero_a: assert property (
    rd && ctl && prdata[1] |-> !prdata[7]) else $error("gate bit read with ext source");
  slverr_map_a: assert property (acc |-> pslverr == bad) else $error("pslverr wrong");
  slverr_only_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  err_read_zero_a: assert property (rd && bad |-> prdata == 0) else $error("unmapped data");
  rdata_hold_a: assert property (rd |=> $stable(prdata)) else $error("prdata moved");
  mask_off_irq_a: assert property (
    acc && pwrite && paddr == 12'h024 && pwdata == 0 |=> !irq) else $error("irq unmasked");
  reset_quiet_a: assert property ($fell(reset) |-> !irq && !pslverr) else $error("reset noise");
endmodule
bind tbtc_timer_pair tbtc_props i_tbtc_props (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .irq(irq));

// *** test/tbtc_timer_pair_bench.sv ***
// Purpose: register level test of the timer pair
// Assumes: apb master, 50 MHz clock
// Notes:   count windows carry a small slack for sync and prescaler phase
`timescale 1ns/1ps
module tbtc_timer_pair_bench;
  reg         clock = 0;
  reg         reset = 1;
  reg         psel = 0;
  reg         penable = 0;
  reg         pwrite = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0;
  reg         deviceIdle = 0;
  reg         extClockEven = 0;
  reg         gateEven = 0;
  reg         extClockOdd = 0;
  reg         gateOdd = 0;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire        irq;
  reg  [31:0] rdata;
  reg         rerr;
  integer     err_total = 0;
  integer     compares = 0;
  integer     i;
  tbtc_timer_pair i_tbtc_timer_pair (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .deviceIdle(deviceIdle), .extClockEven(extClockEven), .extClockOdd(extClockOdd),
    .gateEven(gateEven), .gateOdd(gateOdd), .irq(irq));
  always #10 clock = ~clock;
  // ****
  // tasks
  // ****
  task complete_run;
    begin
      if (err_total == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task near(input [31:0] got, input [31:0] exp, input [31:0] tol);
    begin
      compares = compares + 1;
      if ((^got === 1'bx) || got + tol < exp || got > exp + tol) begin
        err_total = err_total + 1;
        $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input wr, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      @(posedge clock);
      while (pready !== 1'b1 && n < 16) begin
        @(posedge clock);
        n = n + 1;
      end
      if (pready !== 1'b1) begin
        err_total = err_total + 1;
        complete_run;
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdChk(input [11:0] a, input [31:0] e, input [31:0] t);
    begin
      xfer(1'b0, a, 32'h0);
      near(rdata, e, t);
    end
  endtask
  // disabling last keeps the count still while it is read
  task runFor(input [31:0] c, input integer n);
    begin
      wr(12'h004, 32'h0);
      wr(12'h000, c);
      repeat (n) @(posedge clock);
      wr(12'h000, 32'h0);
    end
  endtask
  initial begin
    #1500000;
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rdChk(12'h000, 32'h0, 0);
    rdChk(12'h008, 32'hFFFF, 0);
    wr(12'h000, 32'hFFFFFFFF);
    wr(12'h010, 32'hFFFFFFFF);
    rdChk(12'h000, 32'h0000A07A, 0);
    rdChk(12'h010, 32'h0000A072, 0);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h80);
    rdChk(12'h000, 32'h80, 0);
    for (i = 0; i < 8; i = i + 1) begin
      runFor(32'h8000 | (i << 4), 1022);
      rdChk(12'h004, 1024 >> (i == 7 ? 8 : i), 2);
      repeat (20) @(posedge clock);
      rdChk(12'h004, 1024 >> (i == 7 ? 8 : i), 2);
    end
    deviceIdle <= 1'b1;
    runFor(32'hA000, 100);
    rdChk(12'h004, 32'h0, 1);
    runFor(32'h8000, 100);
    rdChk(12'h004, 102, 4);
    deviceIdle <= 1'b0;
    runFor(32'h8080, 100);
    rdChk(12'h004, 32'h0, 0);
    gateEven <= 1'b1;
    gateOdd <= 1'b1;
    wr(12'h010, 32'h8080);
    runFor(32'h8080, 100);
    rdChk(12'h004, 102, 4);
    wr(12'h010, 32'h0);
    rdChk(12'h014, 114, 2);
    gateEven <= 1'b0;
    gateOdd <= 1'b0;
    wr(12'h004, 32'h0);
    wr(12'h014, 32'h0);
    wr(12'h000, 32'h8082);
    wr(12'h010, 32'h8082);
    rdChk(12'h000, 32'h8002, 0);
    rdChk(12'h010, 32'h8002, 0);
    for (i = 0; i < 10; i = i + 1) begin
      repeat (4) @(posedge clock);
      extClockEven <= 1'b1;
      extClockOdd <= 1'b1;
      repeat (4) @(posedge clock);
      extClockEven <= 1'b0;
      extClockOdd <= 1'b0;
    end
    repeat (10) @(posedge clock);
    wr(12'h000, 32'h0);
    wr(12'h010, 32'h0);
    rdChk(12'h004, 10, 0);
    rdChk(12'h014, 10, 0);
    wr(12'h024, 32'h1);
    wr(12'h008, 32'h4);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h8000);
    i = 0;
    while (irq !== 1'b1 && i < 50) begin
      @(posedge clock);
      i = i + 1;
    end
    if (irq !== 1'b1) begin
      err_total = err_total + 1;
      complete_run;
    end
    near(i, 5, 2);
    wr(12'h000, 32'h0);
    rdChk(12'h004, 2, 2);
    rdChk(12'h020, 32'h1, 0);
    rdChk(12'h020, 32'h0, 0);
    near(irq, 0, 0);
    wr(12'h024, 32'h0);
    wr(12'h008, 32'hFFFF);
    wr(12'h004, 32'hFFF8);
    wr(12'h014, 32'h0);
    wr(12'h010, 32'h00000072);
    wr(12'h000, 32'h8008);
    repeat (30) @(posedge clock);
    wr(12'h000, 32'h0);
    rdChk(12'h014, 32'h1, 0);
    rdChk(12'h004, 32'h18, 2);
    wr(12'h004, 32'h0);
    wr(12'h010, 32'h2000);
    deviceIdle <= 1'b1;
    wr(12'h000, 32'h8008);
    repeat (20) @(posedge clock);
    wr(12'h000, 32'h0);
    rdChk(12'h004, 32'h0, 0);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h8008);
    repeat (20) @(posedge clock);
    wr(12'h000, 32'h0);
    rdChk(12'h004, 23, 2);
    deviceIdle <= 1'b0;
    wr(12'h030, 32'h1234);
    near(rerr, 1, 0);
    rdChk(12'h030, 32'h0, 0);
    near(rerr, 1, 0);
    complete_run;
  end
endmodule
